// [verilog/wdt_pkg.sv]
// Shared constants for the watchdog timer: register map, fields, reset values and timing
package wdt_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses on APB)
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS    = 8'h00;   // watchdog_control_reg
    localparam logic [7:0] STATUS_OFS  = 8'h04;   // Status flags, read only
    localparam logic [7:0] COUNT_OFS   = 8'h08;   // Live millisecond count, read only

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int SW_EN_BIT     = 0;             // sw_wdt_enable in control
    localparam int PERIOD_LSB    = 1;             // wdt_period_select low bit
    localparam int PERIOD_W      = 5;             // wdt_period_select width
    localparam int EXPIRED_BIT   = 0;             // wdt_expired_flag_n in status
    localparam int SLEPT_BIT     = 1;             // sleep_entered_flag_n in status
    localparam int ACTIVE_BIT    = 2;             // Watchdog currently active
    localparam int HOLD_BIT      = 3;             // Held cleared until start-up timer ends

    // ------------------------------------------------------------------
    // Reset values and top period code
    // ------------------------------------------------------------------
    localparam logic [4:0] PERIOD_RST = 5'h0b;    // 2048 ms, nominal two seconds
    localparam logic       SW_EN_RST  = 1'b0;     // Software enable off
    localparam logic [4:0] PERIOD_MAX = 5'h12;    // 2^18 ms, nominal 256 seconds

    // ------------------------------------------------------------------
    // Mode and clock-source encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] MODE_ON     = 2'h3;    // Always active
    localparam logic [1:0] MODE_AWAKE  = 2'h2;    // Active only while awake
    localparam logic [1:0] MODE_SW     = 2'h1;    // Follows sw_wdt_enable
    localparam logic [1:0] MODE_OFF    = 2'h0;    // Disabled

    localparam logic [2:0] CLK_LP      = 3'h0;    // low_power_crystal_mode
    localparam logic [2:0] CLK_XT      = 3'h1;    // crystal_osc_mode
    localparam logic [2:0] CLK_HS      = 3'h2;    // high_speed_crystal_mode
    localparam logic [2:0] CLK_EXTERNAL_RC_MODE   = 3'h3;    // external_rc_mode
    localparam logic [2:0] CLK_INTERNAL_OSC_MODE  = 3'h4;    // internal_osc_mode
    localparam logic [2:0] CLK_EXTERNAL_CLOCK_INPUT  = 3'h5;    // external_clock_input
    localparam logic [2:0] CLK_SECOSC  = 3'h6;    // secondary_osc_mode

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int LF_OSC_HZ   = 31000;           // low_freq_internal_osc rate
    localparam int BASE_US     = 1000;            // Nominal base interval, 1 ms
    localparam int TICK_DIV    = (LF_OSC_HZ * BASE_US + 999999) / 1000000; // Osc edges per ms
    localparam int DIV_W       = 5;               // Prescaler width
    localparam int CNT_W       = 19;              // Millisecond counter width

endpackage : wdt_pkg

// [verilog/tick_if.sv]
// Carrier between the watchdog core and its 1 ms base tick generator
`timescale 1ns/1ns
interface tick_if;
    logic clear;   // Restart the prescaler
    logic tick;    // One-cycle base tick
    modport gen  (input clear, output tick);
    modport user (output clear, input tick);
endinterface : tick_if

// [verilog/wdt_tick_gen.sv]
// Base tick generator: divides low-frequency oscillator edges into 1 ms ticks
`timescale 1ns/1ns
module wdt_tick_gen
    import wdt_pkg::*;
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // Oscillator level, sampled on ref_clk
    input  wire logic lf_osc,
    // Tick carrier
    tick_if.gen       tk
);
    import wdt_pkg::*;

    logic             lf_prev_reg;   // Previous oscillator level
    logic             lf_prev_next;
    logic [DIV_W-1:0] div_reg;       // Oscillator edge count in this interval
    logic [DIV_W-1:0] div_next;
    logic             tick_reg;      // Registered tick
    logic             tick_next;
    logic             lf_rise;       // Rising edge of oscillator

    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);

    // ------------------------------------------------------------------
    // Prescaler next state
    // ------------------------------------------------------------------
    always_comb begin
        lf_rise      = lf_osc & ~lf_prev_reg;
        lf_prev_next = lf_osc;
        div_next     = div_reg;
        tick_next    = 1'b0;
        if (tk.clear) begin
            // Restart so the first interval after a clear is a full one
            div_next = '0;
        end else if (lf_rise) begin
            if (div_reg == DIV_LAST) begin
                div_next  = '0;
                tick_next = 1'b1;
            end else begin
                div_next = div_reg + 1'b1;
            end
        end
    end

    // Registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lf_prev_reg <= 1'b0;
            div_reg     <= '0;
            tick_reg    <= 1'b0;
        end else begin
            lf_prev_reg <= lf_prev_next;
            div_reg     <= div_next;
            tick_reg    <= tick_next;
        end
    end

    assign tk.tick = tick_reg;

    a_tick_spacing: assert property (@(posedge ref_clk) disable iff (rst)
        tk.tick |-> (div_reg == '0) && ($past(div_reg) == DIV_LAST)
                    && $past(lf_rise) && !$past(tk.clear))
        else $error("base tick not on the last oscillator edge");

endmodule : wdt_tick_gen

// [verilog/watchdog_timer.sv]
// Watchdog timer top: APB registers, mode decode, counter, clearing, time-out actions
//
// Contract
// - Count 1 ms ticks of low-frequency oscillator
// - Two-bit mode: on, awake-only, software, off
// - Software mode follows enable bit only
// - Period selectable 1 ms to 256 s
// - Period resets to two-second encoding
// - Clear on reset, instruction, sleep, fail, disable
// - Crystal wake holds clear until start-up ends
// - Counting restarts from zero in sleep
// - Sleep time-out wakes, never resets
// - Time-out drives active-low expired flag low
// - Oscillator divider change leaves counter alone
`timescale 1ns/1ns
module watchdog_timer
    import wdt_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Oscillator and configuration
    input  wire logic        lf_osc,
    input  wire logic [1:0]  wdt_mode_cfg,
    input  wire logic [2:0]  sys_clk_src,
    // Core events
    input  wire logic        sleep_mode,
    input  wire logic        clear_watchdog_instr,
    input  wire logic        osc_fail,
    input  wire logic        ost_done,
    // Outputs to the core
    output logic             wdt_reset,
    output logic             wdt_wake
);
    import wdt_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic                sw_en_reg;         // sw_wdt_enable
    logic                sw_en_next;
    logic [PERIOD_W-1:0] period_reg;        // wdt_period_select
    logic [PERIOD_W-1:0] period_next;
    logic                to_n_reg;          // wdt_expired_flag_n
    logic                to_n_next;
    logic                pd_n_reg;          // sleep_entered_flag_n
    logic                pd_n_next;
    logic [CNT_W-1:0]    cnt_reg;           // Elapsed milliseconds
    logic [CNT_W-1:0]    cnt_next;
    logic                sleep_prev_reg;    // Sleep level one cycle ago
    logic                sleep_prev_next;
    logic                hold_reg;          // Waiting for start-up timer
    logic                hold_next;
    logic                reset_reg;         // Reset pulse to core
    logic                reset_next;
    logic                wake_reg;          // Wake pulse to core
    logic                wake_next;
    logic [31:0]         prdata_reg;        // Read data
    logic [31:0]         prdata_next;
    logic                pready_reg;        // Access completes
    logic                pready_next;
    logic                pslverr_reg;       // Unmapped address
    logic                pslverr_next;

    logic                active;            // Watchdog counting permitted
    logic                sleep_rise;        // Sleep entry
    logic                sleep_fall;        // Wake from sleep
    logic                clr_cnt;           // Counter clear this cycle
    logic                timeout;           // Period reached on this tick
    logic                bus_wr;            // Completing write
    logic                bus_rd;            // Read in its wait-state cycle, data out next
    logic                mapped;            // Address decodes to a register

    tick_if tk ();

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Last count value for a period code; codes above the top clamp to 256 s
    function automatic logic [CNT_W-1:0] period_last(input logic [PERIOD_W-1:0] sel);
        logic [PERIOD_W-1:0] s;
        s = (sel > PERIOD_MAX) ? PERIOD_MAX : sel;
        return (CNT_W'(1) << s) - CNT_W'(1);
    endfunction : period_last

    // Crystal sources need the start-up timer after wake
    function automatic logic is_crystal(input logic [2:0] src);
        return (src == CLK_XT) || (src == CLK_HS) || (src == CLK_LP);
    endfunction : is_crystal

    // ------------------------------------------------------------------
    // Base tick
    // ------------------------------------------------------------------
    wdt_tick_gen u_tick (
        .ref_clk (ref_clk),
        .rst     (rst),
        .lf_osc  (lf_osc),
        .tk      (tk.gen)
    );

    // ------------------------------------------------------------------
    // Mode decode and clear sources
    // ------------------------------------------------------------------
    always_comb begin
        unique case (wdt_mode_cfg)
            MODE_ON:    active = 1'b1;
            MODE_AWAKE: active = ~sleep_mode;
            MODE_SW:    active = sw_en_reg;
            MODE_OFF:   active = 1'b0;
        endcase
        sleep_rise = sleep_mode & ~sleep_prev_reg;
        sleep_fall = ~sleep_mode & sleep_prev_reg;
        // No divider input exists here, so divider changes cannot clear it
        clr_cnt    = ~active | clear_watchdog_instr | sleep_rise
                   | sleep_fall | osc_fail | hold_reg;
        timeout    = tk.tick & ~clr_cnt & (cnt_reg == period_last(period_reg));
    end

    assign tk.clear = clr_cnt;

    // ------------------------------------------------------------------
    // Counter, hold and time-out actions
    // ------------------------------------------------------------------
    always_comb begin
        cnt_next        = cnt_reg;
        hold_next       = hold_reg;
        sleep_prev_next = sleep_mode;
        reset_next      = 1'b0;
        wake_next       = 1'b0;
        // Crystal wake keeps the counter cleared until start-up completes
        if (sleep_fall && is_crystal(sys_clk_src)) begin
            hold_next = 1'b1;
        end else if (ost_done) begin
            hold_next = 1'b0;
        end
        if (clr_cnt || timeout) begin
            cnt_next = '0;
        end else if (tk.tick) begin
            cnt_next = cnt_reg + 1'b1;
        end
        if (timeout) begin
            if (sleep_mode) begin
                wake_next = 1'b1;
            end else begin
                reset_next = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Status flags: hardware events win over the restoring instruction
    // ------------------------------------------------------------------
    always_comb begin
        to_n_next = to_n_reg;
        pd_n_next = pd_n_reg;
        if (clear_watchdog_instr) begin
            to_n_next = 1'b1;
            pd_n_next = 1'b1;
        end
        if (sleep_rise) begin
            pd_n_next = 1'b0;
        end
        if (timeout) begin
            to_n_next = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // APB slave: one wait state, then pready with data
    // ------------------------------------------------------------------
    always_comb begin
        mapped       = (paddr == CTRL_OFS) || (paddr == STATUS_OFS) || (paddr == COUNT_OFS);
        bus_wr       = psel & penable & pready_reg & pwrite;
        bus_rd       = psel & penable & ~pready_reg & ~pwrite;
        pready_next  = psel & penable & ~pready_reg;
        pslverr_next = psel & penable & ~pready_reg & ~mapped;
        prdata_next  = pready_next ? 32'h0000_0000 : prdata_reg;
        sw_en_next   = sw_en_reg;
        period_next  = period_reg;
        if (bus_rd) begin
            unique case (paddr)
                CTRL_OFS: begin
                    prdata_next[SW_EN_BIT]                     = sw_en_reg;
                    prdata_next[PERIOD_LSB +: PERIOD_W]        = period_reg;
                end
                STATUS_OFS: begin
                    prdata_next[EXPIRED_BIT]                   = to_n_reg;
                    prdata_next[SLEPT_BIT]                     = pd_n_reg;
                    prdata_next[ACTIVE_BIT]                    = active;
                    prdata_next[HOLD_BIT]                      = hold_reg;
                end
                COUNT_OFS: begin
                    prdata_next[CNT_W-1:0]                     = cnt_reg;
                end
                default: begin
                    prdata_next = 32'h0000_0000;
                end
            endcase
        end
        // Writes land on the completing edge only; status and count ignore writes
        if (bus_wr && (paddr == CTRL_OFS)) begin
            sw_en_next  = pwdata[SW_EN_BIT];
            period_next = pwdata[PERIOD_LSB +: PERIOD_W];
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sw_en_reg      <= SW_EN_RST;
            period_reg     <= PERIOD_RST;
            to_n_reg       <= 1'b1;
            pd_n_reg       <= 1'b1;
            cnt_reg        <= '0;
            sleep_prev_reg <= 1'b0;
            hold_reg       <= 1'b0;
            reset_reg      <= 1'b0;
            wake_reg       <= 1'b0;
            prdata_reg     <= 32'h0000_0000;
            pready_reg     <= 1'b0;
            pslverr_reg    <= 1'b0;
        end else begin
            sw_en_reg      <= sw_en_next;
            period_reg     <= period_next;
            to_n_reg       <= to_n_next;
            pd_n_reg       <= pd_n_next;
            cnt_reg        <= cnt_next;
            sleep_prev_reg <= sleep_prev_next;
            hold_reg       <= hold_next;
            reset_reg      <= reset_next;
            wake_reg       <= wake_next;
            prdata_reg     <= prdata_next;
            pready_reg     <= pready_next;
            pslverr_reg    <= pslverr_next;
        end
    end

    assign prdata    = prdata_reg;
    assign pready    = pready_reg;
    assign pslverr   = pslverr_reg;
    assign wdt_reset = reset_reg;
    assign wdt_wake  = wake_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_period_reset: assert property (@(posedge ref_clk) disable iff (rst)
        $past(rst) |-> period_reg == PERIOD_RST)
        else $error("period not at two-second code after reset");

    a_sw_mode_sleep: assert property (@(posedge ref_clk) disable iff (rst)
        (wdt_mode_cfg == MODE_SW) |-> active == sw_en_reg)
        else $error("software mode active does not follow enable");

    a_awake_mode: assert property (@(posedge ref_clk) disable iff (rst)
        (wdt_mode_cfg == MODE_AWAKE) && sleep_mode |-> !active)
        else $error("awake-only mode active in sleep");

    a_clear_instr: assert property (@(posedge ref_clk) disable iff (rst)
        clear_watchdog_instr || osc_fail || !active |=> cnt_reg == '0)
        else $error("counter not cleared");

    a_sleep_restart: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(sleep_mode) |=> cnt_reg == '0 ##1 (cnt_reg <= 19'h1))
        else $error("counter did not restart at sleep entry");

    a_ost_hold: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(sleep_mode) && is_crystal(sys_clk_src) && !ost_done
        |=> hold_reg ##1 cnt_reg == '0)
        else $error("counter not held after crystal wake");

    a_sleep_wake: assert property (@(posedge ref_clk) disable iff (rst)
        timeout && sleep_mode |=> wdt_wake && !wdt_reset)
        else $error("sleep time-out did not wake cleanly");

    a_awake_reset: assert property (@(posedge ref_clk) disable iff (rst)
        timeout && !sleep_mode |=> wdt_reset && !wdt_wake)
        else $error("awake time-out did not reset");

    a_expired_flag: assert property (@(posedge ref_clk) disable iff (rst)
        timeout |=> !to_n_reg)
        else $error("expired flag not driven low");

    a_sleep_flag: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(sleep_mode) |=> !pd_n_reg)
        else $error("sleep flag not driven low");

    a_period_span: assert property (@(posedge ref_clk) disable iff (rst)
        timeout |-> cnt_reg == period_last(period_reg) && cnt_reg <= 19'h3ffff)
        else $error("time-out outside selected period");

endmodule : watchdog_timer

// [bench/watchdog_timer_tb_top.sv]
// Self-checking testbench for the watchdog timer
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] t=%0t got %h exp %h", $time, (g), (e)); end end
module watchdog_timer_tb_top;
    import wdt_pkg::*;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    typedef struct packed { logic [31:0] m; logic [31:0] d; logic e; } note_t;
    logic        ref_clk, rst, psel, penable, pwrite;   // Clock, reset, APB strobes
    logic [7:0]  paddr;                                 // APB address
    logic [31:0] pwdata, prdata;                        // APB data
    logic        pready, pslverr;                       // APB answer
    logic [1:0]  lf_div = 2'h0;                         // Fast stand-in oscillator
    logic        lf_osc_w;                              // Oscillator level to the design
    logic [1:0]  wdt_mode_cfg;                          // Mode field
    logic [2:0]  sys_clk_src;                           // System clock source
    logic        sleep_mode, clr_instr, osc_fail, ost_done;
    logic        wdt_reset, wdt_wake;                   // Time-out actions
    logic [4:0]  sel;                                   // Chosen period code
    note_t       exp_q[$];                              // Expected APB answers
    note_t       note;                                  // Note being checked
    int          err_count = 0, cmp_count = 0;          // Report counters
    int          n_rst = 0, n_wake = 0, r0, md, sw, sl; // Event counts, loop vars
    // Oscillator edge every four clocks keeps a 1 ms tick at 124 cycles
    assign lf_osc_w = lf_div[1];
    watchdog_timer uut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lf_osc(lf_osc_w), .wdt_mode_cfg(wdt_mode_cfg),
        .sys_clk_src(sys_clk_src), .sleep_mode(sleep_mode), .clear_watchdog_instr(clr_instr),
        .osc_fail(osc_fail), .ost_done(ost_done), .wdt_reset(wdt_reset), .wdt_wake(wdt_wake));
    // ------------------------------------------------------------------
    // Clock, oscillator and event counters
    // ------------------------------------------------------------------
    initial ref_clk = 1'b0;
    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        lf_div <= lf_div + 2'h1;
        if (wdt_reset === 1'b1) n_rst++;
        if (wdt_wake === 1'b1) n_wake++;
    end
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task results;
        $display("Counts: %0d compares, %0d mismatches", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc
    // One APB transfer; the expected answer is queued before the request goes out
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       input logic [31:0] m, input logic [31:0] d, input logic e);
        int n;
        exp_q.push_back('{m: m, d: d & m, e: e});
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_count++;
            results();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic pulse_clr;
        @(posedge ref_clk);
        clr_instr <= 1'b1;
        @(posedge ref_clk);
        clr_instr <= 1'b0;
    endtask : pulse_clr
    // Wait for a reset or wake pulse; the window absorbs oscillator phase
    task automatic wait_evt(input bit wk, input int lo, input int hi);
        int n0, n;
        n0 = wk ? n_wake : n_rst;
        n = 0;
        while ((wk ? n_wake : n_rst) == n0 && n <= hi) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        `CHK(n >= lo && n <= hi, 1'b1)
    endtask : wait_evt
    // ------------------------------------------------------------------
    // Answer monitor: oldest note against each completed transfer
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (pready === 1'b1) begin
            if (exp_q.size() == 0) begin
                err_count++;
                $display("[ERR] t=%0t got %h exp %h", $time, prdata, 32'h0);
            end else begin
                note = exp_q.pop_front();
                `CHK(prdata & note.m, note.d)
                `CHK(pslverr, note.e)
            end
        end
    end
    initial begin
        #(40 * 100000);
        err_count++;
        results();
    end
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'hec60a535));
        {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
        {wdt_mode_cfg, sys_clk_src} = {MODE_OFF, CLK_INTERNAL_OSC_MODE};
        {sleep_mode, clr_instr, osc_fail, ost_done} = 4'h0;
        cyc(10);
        rst <= 1'b0;
        // Reset values, read-only status, unmapped place, widest period code
        apb(0, CTRL_OFS, 0, 32'h3f, {26'h0, PERIOD_RST, SW_EN_RST}, 0);
        apb(0, STATUS_OFS, 0, 32'h3, 32'h3, 0);
        apb(1, STATUS_OFS, 0, 0, 0, 0);
        apb(0, STATUS_OFS, 0, 32'h3, 32'h3, 0);
        apb(0, 8'h0c, 0, 32'hffffffff, 0, 1);
        apb(1, CTRL_OFS, {26'h0, PERIOD_MAX, 1'b0}, 0, 0, 0);
        apb(0, CTRL_OFS, 0, 32'h3e, {26'h0, PERIOD_MAX, 1'b0}, 0);
        $display("test reset_map done");
        // Every mode against enable bit and sleep state
        for (md = 0; md < 4; md++) begin
            for (sw = 0; sw < 2; sw++) begin
                for (sl = 0; sl < 2; sl++) begin
                    wdt_mode_cfg <= md[1:0];
                    sleep_mode   <= sl[0];
                    apb(1, CTRL_OFS, {26'h0, PERIOD_RST, sw[0]}, 0, 0, 0);
                    apb(0, STATUS_OFS, 0, 32'h4, {29'h0, md == 3 || (md == 2 && sl == 0)
                        || (md == 1 && sw == 1), 2'h0}, 0);
                end
            end
        end
        sleep_mode <= 1'b0;
        $display("test modes done");
        // Awake time-out with a random short period, then expired flag restored by clear
        sel = 5'($urandom % 3);
        wdt_mode_cfg <= MODE_ON;
        apb(1, CTRL_OFS, {26'h0, sel, 1'b0}, 0, 0, 0);
        pulse_clr();
        wait_evt(0, 124 * (1 << sel) - 12, 124 * (1 << sel) + 12);
        apb(0, STATUS_OFS, 0, 32'h1, 32'h0, 0);
        pulse_clr();
        apb(0, STATUS_OFS, 0, 32'h1, 32'h1, 0);
        $display("test awake_timeout done");
        // Clear instructions and oscillator failure keep the count from expiring
        apb(1, CTRL_OFS, {26'h0, 5'h02, 1'b0}, 0, 0, 0);
        r0 = n_rst;
        repeat (5) begin
            pulse_clr();
            cyc(300);
        end
        `CHK(n_rst, r0)
        osc_fail <= 1'b1;
        cyc(600);
        apb(0, COUNT_OFS, 0, 32'h7ffff, 0, 0);
        `CHK(n_rst, r0)
        osc_fail <= 1'b0;
        $display("test clearing done");
        // Time-out while asleep wakes and never resets
        apb(1, CTRL_OFS, {26'h0, 5'h01, 1'b0}, 0, 0, 0);
        r0 = n_rst;
        sleep_mode <= 1'b1;
        wait_evt(1, 248 - 12, 248 + 12);
        `CHK(n_rst, r0)
        apb(0, STATUS_OFS, 0, 32'h1, 32'h0, 0);
        sleep_mode <= 1'b0;
        pulse_clr();
        $display("test sleep_timeout done");
        // Crystal wake holds the count until the start-up timer ends
        sys_clk_src <= CLK_XT;
        apb(1, CTRL_OFS, {26'h0, 5'h00, 1'b0}, 0, 0, 0);
        sleep_mode <= 1'b1;
        cyc(10);
        sleep_mode <= 1'b0;
        r0 = n_rst;
        cyc(400);
        apb(0, STATUS_OFS, 0, 32'h8, 32'h8, 0);
        apb(0, COUNT_OFS, 0, 32'h7ffff, 0, 0);
        `CHK(n_rst, r0)
        ost_done <= 1'b1;
        cyc(1);
        ost_done <= 1'b0;
        apb(0, STATUS_OFS, 0, 32'h8, 32'h0, 0);
        wait_evt(0, 124 - 12, 124 + 12);
        cyc(1);
        sys_clk_src <= CLK_INTERNAL_OSC_MODE;
        $display("test crystal_wake done");
        results();
    end
endmodule : watchdog_timer_tb_top
